// *** hw/hfesc_pkg.sv ***
// package for the fault escalation logic: register map, field positions, types
// assumes a plain register port with one-cycle read latency
package hfesc_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [3:0] HFESC_ADDR_STATUS  = 4'h0;
  localparam logic [3:0] HFESC_ADDR_CONTROL = 4'h4;
  localparam logic [3:0] HFESC_ADDR_STATE   = 4'h8;

  // ----------------------------------------------------------------------
  // status fields
  // ----------------------------------------------------------------------
  localparam int HFESC_BIT_DEBUG_EVENT = 31;
  localparam int HFESC_BIT_ESCALATED   = 30;
  localparam int HFESC_BIT_VECTOR_FAIL = 1;
  localparam logic [31:0] HFESC_STATUS_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------------
  localparam int HFESC_BIT_MASK      = 0;
  localparam int HFESC_BIT_PROT_TOP  = 1;
  localparam int HFESC_BIT_STK_IGN   = 2;
  localparam int HFESC_BIT_BUS_IGN   = 3;
  localparam int HFESC_BIT_CFG_EN_LO = 4;
  localparam logic [31:0] HFESC_CONTROL_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    HFESC_ACT_NONE     = 2'b00,
    HFESC_ACT_ESCALATE = 2'b01,
    HFESC_ACT_TAKE_NOW = 2'b10,
    HFESC_ACT_PEND     = 2'b11
  } hfesc_action_type;

  typedef struct packed {
    logic       valid;
    logic [1:0] cls;
    logic       is_lazy;
    logic       is_stack;
  } hfesc_fault_type;

  typedef struct packed {
    logic [1:0] outcome;
    logic [1:0] cls;
  } hfesc_decision_type;

endpackage

// *** hw/hfesc_core.sv ***
// fault escalation logic of the exception unit
// assumes synchronous inputs on sys_clk_i; priorities signed, lower value = higher urgency
// What this block does
// - vector fetch bus error raises the unrecoverable fault
// - vector fetch security violation raises the unrecoverable fault
// - supervisor call at blocked priority raises the unrecoverable fault
// - breakpoint instruction with debug disabled raises the unrecoverable fault
// - disabled configurable fault escalates to the unrecoverable fault
// - debug-caused fault sets status bit 31
// - escalated fault sets status bit 30
// - vector fetch failure sets status bit 1
// - status flags stay set until software writes one to clear
// - stacking errors are judged against the interrupted code priority
// - stacking error escalates if fault disabled or not above interrupted code
// - fault above both levels runs first, incoming exception stays pending
// - fault between levels runs after the incoming exception handler
// - deferred float save fault follows the stacking fault ladder but never pends the incoming exception
// - deferred save fault above running handler is taken at once
// - deferred save fault above interrupted code but not above running handler pends until it ends
// - escalation mask blocks all exceptions except the nonmaskable interrupt
// - protection enable resets to zero, zero disables protection at -1 and -2
// - stack limit ignore skips the check at priority -1
// - bus fault ignore suppresses data bus faults at -1 and -2
`timescale 1ns/10ps
module hfesc_core
  import hfesc_pkg::*;
#(
  parameter int PRIO_W = 9
) (
  input  wire logic              sys_clk_i,
  input  wire logic              reset_n_i,
  input  wire logic [3:0]        reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_write_i,
  input  wire logic              reg_read_i,
  output logic      [31:0]       reg_rdata_o,
  input  wire logic              vec_bus_err_i,
  input  wire logic              vec_sec_err_i,
  input  wire logic              svc_exec_i,
  input  wire logic signed [PRIO_W-1:0] svc_prio_i,
  input  wire logic signed [PRIO_W-1:0] exec_prio_i,
  input  wire logic              breakpoint_instruction_exec_i,
  input  wire logic              debug_enabled_i,
  input  wire logic              debug_event_i,
  input  wire hfesc_fault_type   fault_i,
  input  wire logic signed [PRIO_W-1:0] fault_prio_i,
  input  wire logic signed [PRIO_W-1:0] interrupted_prio_i,
  input  wire logic signed [PRIO_W-1:0] incoming_prio_i,
  input  wire logic              data_bus_err_i,
  input  wire logic              stack_limit_hit_i,
  input  wire logic              nmi_req_i,
  input  wire logic              exc_req_i,
  output logic                   hard_fault_o,
  output hfesc_decision_type     decision_o,
  output logic                   incoming_pend_o,
  output logic                   exc_allowed_o,
  output logic                   nmi_allowed_o,
  output logic                   prot_active_o,
  output logic                   stack_check_active_o,
  output logic                   data_bus_fault_o
);

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (PRIO_W < 3 || PRIO_W > 16) begin : g_bad_w
    $error("PRIO_W out of range");
  end

  localparam logic signed [PRIO_W-1:0] PRIO_M1 = PRIO_W'(-1);
  localparam logic signed [PRIO_W-1:0] PRIO_M2 = PRIO_W'(-2);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic outranks(input logic signed [PRIO_W-1:0] a,
                                    input logic signed [PRIO_W-1:0] b);
    outranks = (a < b);
  endfunction

  function automatic logic is_top_prio(input logic signed [PRIO_W-1:0] p);
    is_top_prio = (p == PRIO_M1) || (p == PRIO_M2);
  endfunction

  // ----------------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------------
  logic [31:0] control_q;
  logic        mask_set;
  logic        prot_top_en;
  logic        stk_ign;
  logic        bus_ign;
  logic [3:0]  cfg_en;
  logic        wr_status;
  logic        wr_control;

  assign wr_status   = reg_write_i && (reg_addr_i == HFESC_ADDR_STATUS);
  assign wr_control  = reg_write_i && (reg_addr_i == HFESC_ADDR_CONTROL);
  assign mask_set    = control_q[HFESC_BIT_MASK];
  assign prot_top_en = control_q[HFESC_BIT_PROT_TOP];
  assign stk_ign     = control_q[HFESC_BIT_STK_IGN];
  assign bus_ign     = control_q[HFESC_BIT_BUS_IGN];
  assign cfg_en      = control_q[HFESC_BIT_CFG_EN_LO +: 4];

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      control_q <= HFESC_CONTROL_RESET;
    end else if (wr_control) begin
      control_q <= {24'h00_0000, reg_wdata_i[7:0]};
    end
  end

  // ----------------------------------------------------------------------
  // stacking and deferred save fault decision
  // ----------------------------------------------------------------------
  logic        cfg_on;
  logic [1:0]  outcome;
  logic        pend_incoming;

  assign cfg_on = cfg_en[fault_i.cls];

  always_comb begin
    outcome       = HFESC_ACT_NONE;
    pend_incoming = 1'b0;
    if (fault_i.valid) begin
      if (!cfg_on) begin
        outcome = HFESC_ACT_ESCALATE;
      end else if (fault_i.is_stack || fault_i.is_lazy) begin
        // deferred save uses the same ladder
        if (!outranks(fault_prio_i, interrupted_prio_i)) begin
          outcome = HFESC_ACT_ESCALATE;
        end else if (outranks(fault_prio_i, incoming_prio_i)) begin
          outcome       = HFESC_ACT_TAKE_NOW;
          pend_incoming = fault_i.is_stack;
        end else begin
          outcome = HFESC_ACT_PEND;
        end
      end else begin
        outcome = HFESC_ACT_TAKE_NOW;
      end
    end
  end

  // ----------------------------------------------------------------------
  // unrecoverable fault sources
  // ----------------------------------------------------------------------
  logic vec_fail;
  logic svc_blocked;
  logic breakpoint_instruction_fault;
  logic escalated;
  logic hf_now;

  assign vec_fail    = vec_bus_err_i || vec_sec_err_i;
  assign svc_blocked = svc_exec_i && !outranks(svc_prio_i, exec_prio_i);
  assign breakpoint_instruction_fault  = breakpoint_instruction_exec_i && !debug_enabled_i;
  assign escalated   = (outcome == HFESC_ACT_ESCALATE);
  assign hf_now      = vec_fail || svc_blocked || breakpoint_instruction_fault || escalated || debug_event_i;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hard_fault_o    <= 1'b0;
      decision_o      <= '0;
      incoming_pend_o <= 1'b0;
    end else begin
      hard_fault_o    <= hf_now;
      decision_o      <= '{outcome: outcome, cls: fault_i.cls};
      incoming_pend_o <= pend_incoming;
    end
  end

  // ----------------------------------------------------------------------
  // cause status, write one to clear, set wins
  // ----------------------------------------------------------------------
  logic [31:0] status_q;
  logic [31:0] status_set;

  always_comb begin
    status_set = 32'h0000_0000;
    status_set[HFESC_BIT_DEBUG_EVENT] = debug_event_i;
    status_set[HFESC_BIT_ESCALATED]   = escalated;
    status_set[HFESC_BIT_VECTOR_FAIL] = vec_fail;
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_q <= HFESC_STATUS_RESET;
    end else begin
      status_q <= (status_q & ~(wr_status ? reg_wdata_i : 32'h0000_0000)) | status_set;
    end
  end

  // ----------------------------------------------------------------------
  // top priority overrides
  // ----------------------------------------------------------------------
  logic at_top;

  assign at_top               = is_top_prio(exec_prio_i);
  assign exc_allowed_o        = exc_req_i && !mask_set;
  assign nmi_allowed_o        = nmi_req_i;
  assign prot_active_o        = !(at_top && !prot_top_en);
  assign stack_check_active_o = stack_limit_hit_i && !(stk_ign && exec_prio_i == PRIO_M1);
  assign data_bus_fault_o     = data_bus_err_i && !(bus_ign && at_top);

  // ----------------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_read_i) begin
      unique case (reg_addr_i)
        HFESC_ADDR_STATUS:  reg_rdata_o <= status_q;
        HFESC_ADDR_CONTROL: reg_rdata_o <= control_q;
        HFESC_ADDR_STATE:   reg_rdata_o <= {28'h000_0000, incoming_pend_o,
                                            hard_fault_o, decision_o.outcome};
        default:            reg_rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  sequence s_vec_fail;
    vec_bus_err_i || vec_sec_err_i;
  endsequence

  AST_VEC_HF: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    s_vec_fail |=> hard_fault_o) else $error("vector failure without fault");
  AST_SEC_FLAG: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    vec_sec_err_i |=> status_q[HFESC_BIT_VECTOR_FAIL]) else $error("vector flag not set");
  AST_SVC_HF: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (svc_exec_i && svc_prio_i >= exec_prio_i) |=> hard_fault_o) else $error("svc missed");
  AST_BREAKPOINT_INSTRUCTION_HF: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (breakpoint_instruction_exec_i && !debug_enabled_i) |=> hard_fault_o) else $error("breakpoint_instruction missed");
  AST_DBG_FLAG: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    debug_event_i |=> status_q[HFESC_BIT_DEBUG_EVENT]) else $error("debug flag not set");
  AST_ESC_FLAG: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (fault_i.valid && !cfg_on) |=> status_q[HFESC_BIT_ESCALATED] && hard_fault_o)
    else $error("escalation missed");
  AST_STICKY: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (status_q[HFESC_BIT_ESCALATED] && !(wr_status && reg_wdata_i[HFESC_BIT_ESCALATED]))
    |=> status_q[HFESC_BIT_ESCALATED]) else $error("flag lost");
  AST_STK_LOW: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (fault_i.valid && fault_i.is_stack && cfg_on && fault_prio_i >= interrupted_prio_i)
    |=> decision_o.outcome == HFESC_ACT_ESCALATE) else $error("stack escalate missed");
  AST_STK_PEND: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (fault_i.valid && fault_i.is_stack && cfg_on && fault_prio_i < interrupted_prio_i
     && fault_prio_i < incoming_prio_i) |=> incoming_pend_o) else $error("no pend");
  AST_MASK: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    mask_set |-> !exc_allowed_o && (nmi_allowed_o == nmi_req_i)) else $error("mask leak");
  AST_BUS_IGN: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (bus_ign && exec_prio_i == PRIO_M2) |-> !data_bus_fault_o) else $error("bus fault leak");

  AST_BUS_M1: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (bus_ign && exec_prio_i == PRIO_M1) |-> !data_bus_fault_o) else $error("bus fault leak");

  AST_BUS_KEEP: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !bus_ign |-> data_bus_fault_o == data_bus_err_i) else $error("bus fault lost");

  // ----------------------------------------------------------------------
  // assertions: top priority overrides
  // ----------------------------------------------------------------------
  AST_PROT_TOP: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    ((exec_prio_i == PRIO_M1 || exec_prio_i == PRIO_M2) && !prot_top_en) |-> !prot_active_o)
    else $error("protection on at top priority");

  AST_PROT_LOW: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (exec_prio_i != PRIO_M1 && exec_prio_i != PRIO_M2) |-> prot_active_o)
    else $error("protection off");

  AST_STK_IGN: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (stk_ign && exec_prio_i == PRIO_M1) |-> !stack_check_active_o) else $error("stack check on");

  AST_STK_KEEP: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    exec_prio_i != PRIO_M1 |-> stack_check_active_o == stack_limit_hit_i)
    else $error("stack check lost");

  AST_NMI: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    nmi_req_i |-> nmi_allowed_o) else $error("nmi blocked");

  AST_MASK_OFF: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !mask_set |-> exc_allowed_o == exc_req_i) else $error("exception blocked");

  // ----------------------------------------------------------------------
  // assertions: stacking and deferred save ladder
  // ----------------------------------------------------------------------
  sequence s_stack_cfg;
    fault_i.valid && cfg_on && fault_i.is_stack;
  endsequence

  sequence s_lazy_cfg;
    fault_i.valid && cfg_on && fault_i.is_lazy && !fault_i.is_stack;
  endsequence

  sequence s_above_x;
    fault_prio_i < interrupted_prio_i;
  endsequence

  sequence s_not_above_x;
    fault_prio_i >= interrupted_prio_i;
  endsequence

  sequence s_above_y;
    fault_prio_i < incoming_prio_i;
  endsequence

  sequence s_not_above_y;
    fault_prio_i >= incoming_prio_i;
  endsequence

  AST_STK_RUN: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    s_stack_cfg ##0 s_above_x |=> decision_o.outcome != HFESC_ACT_ESCALATE)
    else $error("stack fault escalated");

  AST_STK_NOW: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    s_stack_cfg ##0 s_above_x ##0 s_above_y |=> decision_o.outcome == HFESC_ACT_TAKE_NOW)
    else $error("stack fault not taken");

  AST_STK_MID: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    s_stack_cfg ##0 s_above_x ##0 s_not_above_y
    |=> decision_o.outcome == HFESC_ACT_PEND && !incoming_pend_o)
    else $error("stack fault not deferred");

  AST_STK_OFF: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (fault_i.valid && fault_i.is_stack && !cfg_on)
    |=> decision_o.outcome == HFESC_ACT_ESCALATE) else $error("disabled stack fault kept");

  AST_LAZY_LOW: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    s_lazy_cfg ##0 s_not_above_x
    |=> decision_o.outcome == HFESC_ACT_ESCALATE && hard_fault_o)
    else $error("deferred fault not escalated");

  AST_LAZY_NOW: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    s_lazy_cfg ##0 s_above_x ##0 s_above_y |=> decision_o.outcome == HFESC_ACT_TAKE_NOW)
    else $error("deferred fault not taken");

  AST_LAZY_PEND: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    s_lazy_cfg ##0 s_above_x ##0 s_not_above_y |=> decision_o.outcome == HFESC_ACT_PEND)
    else $error("deferred fault not pended");

  // ----------------------------------------------------------------------
  // assertions: status flags and reset
  // ----------------------------------------------------------------------
  AST_SEC_HF: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    vec_sec_err_i |=> hard_fault_o) else $error("security vector failure missed");

  AST_BUS_FLAG: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    vec_bus_err_i |=> status_q[HFESC_BIT_VECTOR_FAIL]) else $error("vector flag not set");

  AST_CLEAR: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (wr_status && reg_wdata_i[HFESC_BIT_ESCALATED] && !escalated)
    |=> !status_q[HFESC_BIT_ESCALATED]) else $error("flag not cleared");

  AST_ESC_ONLY: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (!status_q[HFESC_BIT_ESCALATED] && !fault_i.valid)
    |=> !status_q[HFESC_BIT_ESCALATED]) else $error("escalated flag set alone");

  AST_VEC_ONLY: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (!status_q[HFESC_BIT_VECTOR_FAIL] && !vec_bus_err_i && !vec_sec_err_i)
    |=> !status_q[HFESC_BIT_VECTOR_FAIL]) else $error("vector flag set alone");

  AST_DBG_ONLY: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (!status_q[HFESC_BIT_DEBUG_EVENT] && !debug_event_i)
    |=> !status_q[HFESC_BIT_DEBUG_EVENT]) else $error("debug flag set alone");

  for (genvar k = 0; k < 4; k++) begin : g_cls_chk
    AST_CLS_OFF: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (fault_i.valid && fault_i.cls == 2'(k) && !cfg_en[k])
      |=> hard_fault_o && decision_o.cls == 2'(k)) else $error("disabled class kept");
  end

  AST_RST_STATUS: assert property (@(posedge sys_clk_i)
    !reset_n_i |=> status_q == HFESC_STATUS_RESET) else $error("status not cleared");

  AST_RST_CTRL: assert property (@(posedge sys_clk_i)
    !reset_n_i |=> control_q == HFESC_CONTROL_RESET) else $error("control not cleared");

endmodule

// *** verif/hfesc_core_tb_top.sv ***
// self-checking bench for the fault escalation logic: table-driven cases, then hand tests
// assumes hfesc_pkg and hfesc_core are compiled first; 100 MHz clock, async low reset
`timescale 1ns/10ps
module hfesc_core_tb_top
  import hfesc_pkg::*;
;
  // ----------------------------------------------------------------------
  // signals and tables
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]        ctrl;
    logic [5:0]        ev;
    logic signed [8:0] svcp, ep, fp, xp, yp;
    logic [4:0]        f;
    logic              hf;
    logic [1:0]        oc;
    logic              pend;
    logic [31:0]       st;
  } hfesc_ev_row_type;
  typedef struct packed {
    logic [3:0]        c;
    logic signed [8:0] p;
    logic [3:0]        in;
    logic [4:0]        out;
  } hfesc_cb_row_type;

  logic                sys_clk_i = 1'b0;
  logic                reset_n_i;
  logic [3:0]          reg_addr_i;
  logic [31:0]         reg_wdata_i, reg_rdata_o;
  logic                reg_write_i, reg_read_i;
  logic                vec_bus_err_i, vec_sec_err_i, svc_exec_i, breakpoint_instruction_exec_i;
  logic                debug_enabled_i, debug_event_i;
  logic signed [8:0]   svc_prio_i, exec_prio_i, fault_prio_i, interrupted_prio_i;
  logic signed [8:0]   incoming_prio_i;
  hfesc_fault_type     fault_i;
  logic                data_bus_err_i, stack_limit_hit_i, nmi_req_i, exc_req_i;
  logic                hard_fault_o, incoming_pend_o, exc_allowed_o, nmi_allowed_o;
  logic                prot_active_o, stack_check_active_o, data_bus_fault_o;
  hfesc_decision_type  decision_o;
  int                  mismatches = 0;
  int                  num_checks = 0;
  hfesc_ev_row_type    r;
  hfesc_cb_row_type    c;

  // ev bits: vector bus error, vector security, svc, breakpoint, debug enabled, debug event
  hfesc_ev_row_type ev_rows [19] = '{
    '{8'h00, 6'h20, 0, 0, 0, 0, 0, 5'h00, 1, 0, 0, 32'h0000_0002},
    '{8'h00, 6'h10, 0, 0, 0, 0, 0, 5'h00, 1, 0, 0, 32'h0000_0002},
    '{8'h00, 6'h08, 5, 3, 0, 0, 0, 5'h00, 1, 0, 0, 32'h0000_0000},
    '{8'h00, 6'h08, 3, 3, 0, 0, 0, 5'h00, 1, 0, 0, 32'h0000_0000},
    '{8'h00, 6'h08, 2, 3, 0, 0, 0, 5'h00, 0, 0, 0, 32'h0000_0000},
    '{8'h00, 6'h04, 0, 0, 0, 0, 0, 5'h00, 1, 0, 0, 32'h0000_0000},
    '{8'h00, 6'h06, 0, 0, 0, 0, 0, 5'h00, 0, 0, 0, 32'h0000_0000},
    '{8'h00, 6'h01, 0, 0, 0, 0, 0, 5'h00, 1, 0, 0, 32'h8000_0000},
    '{8'h00, 6'h00, 0, 0, 0, 0, 0, 5'h10, 1, 1, 0, 32'h4000_0000},
    '{8'h00, 6'h00, 0, 0, 0, 0, 0, 5'h14, 1, 1, 0, 32'h4000_0000},
    '{8'h00, 6'h00, 0, 0, 0, 0, 0, 5'h18, 1, 1, 0, 32'h4000_0000},
    '{8'h00, 6'h00, 0, 0, 0, 0, 0, 5'h1c, 1, 1, 0, 32'h4000_0000},
    '{8'h20, 6'h00, 0, 0, 0, 0, 0, 5'h14, 0, 2, 0, 32'h0000_0000},
    '{8'hf0, 6'h00, 0, 0, 0, 6, 2, 5'h11, 0, 2, 1, 32'h0000_0000},
    '{8'hf0, 6'h00, 0, 0, 4, 6, 2, 5'h11, 0, 3, 0, 32'h0000_0000},
    '{8'hf0, 6'h00, 0, 0, 6, 6, 2, 5'h11, 1, 1, 0, 32'h4000_0000},
    '{8'h00, 6'h00, 0, 0, 0, 6, 2, 5'h11, 1, 1, 0, 32'h4000_0000},
    '{8'hf0, 6'h00, 0, 0, 0, 6, 2, 5'h12, 0, 2, 0, 32'h0000_0000},
    '{8'hf0, 6'h00, 0, 0, 2, 6, 2, 5'h12, 0, 3, 0, 32'h0000_0000}
  };
  // in: data bus error, stack hit, exc request, nmi; out: exc, nmi, prot, stack, bus fault
  hfesc_cb_row_type cb_rows [11] = '{
    '{4'h0, 3, 4'hf, 5'h1f}, '{4'h1, 3, 4'hf, 5'h0f},
    '{4'h0, -1, 4'hf, 5'h1b}, '{4'h0, -2, 4'hf, 5'h1b}, '{4'h2, -1, 4'hf, 5'h1f},
    '{4'h6, -1, 4'hf, 5'h1d}, '{4'h6, -2, 4'hf, 5'h1f},
    '{4'ha, -1, 4'hf, 5'h1e}, '{4'ha, -2, 4'hf, 5'h1e}, '{4'ha, 0, 4'hf, 5'h1f},
    '{4'h1, -1, 4'h5, 5'h0a}
  };

  always #5 sys_clk_i = ~sys_clk_i;

  hfesc_core #(.PRIO_W(9)) dut (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .vec_bus_err_i(vec_bus_err_i), .vec_sec_err_i(vec_sec_err_i),
    .svc_exec_i(svc_exec_i), .svc_prio_i(svc_prio_i), .exec_prio_i(exec_prio_i),
    .breakpoint_instruction_exec_i(breakpoint_instruction_exec_i), .debug_enabled_i(debug_enabled_i),
    .debug_event_i(debug_event_i), .fault_i(fault_i), .fault_prio_i(fault_prio_i),
    .interrupted_prio_i(interrupted_prio_i), .incoming_prio_i(incoming_prio_i),
    .data_bus_err_i(data_bus_err_i), .stack_limit_hit_i(stack_limit_hit_i),
    .nmi_req_i(nmi_req_i), .exc_req_i(exc_req_i), .hard_fault_o(hard_fault_o),
    .decision_o(decision_o), .incoming_pend_o(incoming_pend_o),
    .exc_allowed_o(exc_allowed_o), .nmi_allowed_o(nmi_allowed_o),
    .prot_active_o(prot_active_o), .stack_check_active_o(stack_check_active_o),
    .data_bus_fault_o(data_bus_fault_o));

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // one cycle of write strobe and/or event pulses, all dropped at the next edge
  task automatic step(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [5:0] ev, input logic [4:0] f);
    @(posedge sys_clk_i);
    reg_write_i <= w;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    {vec_bus_err_i, vec_sec_err_i, svc_exec_i, breakpoint_instruction_exec_i, debug_enabled_i, debug_event_i} <= ev;
    fault_i     <= hfesc_fault_type'(f);
    @(posedge sys_clk_i);
    reg_write_i <= 1'b0;
    {vec_bus_err_i, vec_sec_err_i, svc_exec_i, breakpoint_instruction_exec_i, debug_enabled_i, debug_event_i} <= 6'h0;
    fault_i     <= '0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    step(1'b1, a, d, 6'h0, 5'h0);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge sys_clk_i);
    reg_read_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_read_i <= 1'b0;
    @(negedge sys_clk_i);
    chk(reg_rdata_o, e);
  endtask

  task automatic report_and_stop;
    if (mismatches == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------
  initial begin
    {reg_addr_i, reg_wdata_i, reg_write_i, reg_read_i, fault_i} = '0;
    {vec_bus_err_i, vec_sec_err_i, svc_exec_i, breakpoint_instruction_exec_i, debug_enabled_i, debug_event_i} = '0;
    {svc_prio_i, exec_prio_i, fault_prio_i, interrupted_prio_i, incoming_prio_i} = '0;
    {data_bus_err_i, stack_limit_hit_i, nmi_req_i, exc_req_i} = '0;
    reset_n_i = 1'b0;
    repeat (4) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h0);
    rd(4'hc, 32'h0);
    foreach (cb_rows[i]) begin
      c = cb_rows[i];
      wr(4'h4, {28'h0, c.c});
      exec_prio_i <= c.p;
      {data_bus_err_i, stack_limit_hit_i, exc_req_i, nmi_req_i} <= c.in;
      @(negedge sys_clk_i);
      chk(32'({exc_allowed_o, nmi_allowed_o, prot_active_o, stack_check_active_o,
               data_bus_fault_o}), 32'(c.out));
    end
    foreach (ev_rows[i]) begin
      r = ev_rows[i];
      wr(4'h4, {24'h0, r.ctrl});
      wr(4'h0, 32'hffff_ffff);
      @(posedge sys_clk_i);
      svc_prio_i <= r.svcp;
      exec_prio_i <= r.ep;
      fault_prio_i <= r.fp;
      interrupted_prio_i <= r.xp;
      incoming_prio_i <= r.yp;
      step(1'b0, 4'h0, 32'h0, r.ev, r.f);
      @(negedge sys_clk_i);
      chk(32'(hard_fault_o), 32'(r.hf));
      chk(32'(decision_o), r.f[4] ? 32'({r.oc, r.f[3:2]}) : 32'h0);
      if (r.f[4]) chk(32'(incoming_pend_o), 32'(r.pend));
      rd(4'h0, r.st);
    end
    step(1'b0, 4'h0, 32'h0, 6'h0, 5'h11);
    reg_read_i <= 1'b1;
    reg_addr_i <= 4'h8;
    @(posedge sys_clk_i);
    reg_read_i <= 1'b0;
    @(negedge sys_clk_i);
    chk(reg_rdata_o, 32'h0000_0003);
    wr(4'h0, 32'hffff_ffff);
    step(1'b0, 4'h0, 32'h0, 6'h21, 5'h0);
    rd(4'h0, 32'h8000_0002);
    wr(4'h0, 32'h0);
    rd(4'h0, 32'h8000_0002);
    step(1'b1, 4'h0, 32'h2, 6'h20, 5'h0);
    rd(4'h0, 32'h8000_0002);
    wr(4'h0, 32'h8000_0000);
    rd(4'h0, 32'h0000_0002);
    wr(4'h4, 32'hffff_ffff);
    rd(4'h4, 32'h0000_00ff);
    @(posedge sys_clk_i);
    reset_n_i <= 1'b0;
    @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h0);
    report_and_stop();
  end

  // hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    #100000;
    mismatches++;
    report_and_stop();
  end
endmodule
